/* File: core/ids_defs.vh */
`ifndef IDS_DEFS_VH
`define IDS_DEFS_VH

// Clock and time base
`define IDS_CLK_HZ 20000000
`define IDS_TICK_MS 1
`define IDS_TICK_CYC (`IDS_CLK_HZ / 1000 * `IDS_TICK_MS)

// Warning delay before forced switch-off
`define IDS_WARN_MIN 30
`define IDS_WARN_TICKS (`IDS_WARN_MIN * 60000 / `IDS_TICK_MS)
`define IDS_FAIL_DELAY_MIN 0

// Flash timing in milliseconds
`define IDS_FLASH_ON_MS 250
`define IDS_FLASH_OFF_MS 250
`define IDS_FLASH_PAUSE_MS 1000
`define IDS_BLINK_MS 500
`define IDS_COMM_TIMEOUT_MS 100

// Red flash codes
`define IDS_CODE_NONE 3'h0
`define IDS_CODE_OUT1 3'h1
`define IDS_CODE_OUT2 3'h2
`define IDS_CODE_CROSS 3'h3
`define IDS_CODE_TEMP 3'h4
`define IDS_CODE_ACT 3'h5
`define IDS_CODE_HANDLE 3'h6
`define IDS_CODE_STEADY 3'h7

// Register byte addresses
`define IDS_REG_CTRL 12'h000
`define IDS_REG_REQ 12'h004
`define IDS_REG_RESP 12'h008
`define IDS_REG_WARN 12'h00c
`define IDS_REG_FAIL 12'h010
`define IDS_REG_IND 12'h014

// Control register fields
`define IDS_CTRL_LOCKMON 0
`define IDS_CTRL_CODING_LO 1
`define IDS_CTRL_CODING_HI 2
`define IDS_CTRL_SERIAL 3
`define IDS_CTRL_P2UNLOCK 4
`define IDS_CTRL_RESET 5'h01
`define IDS_CODING_STD 2'h0
`define IDS_CODING_INDIV 2'h1
`define IDS_CODING_RETEACH 2'h2

// Byte fields
`define IDS_REQ_MAGNET 0
`define IDS_REQ_RESET 7
`define IDS_DET_COMM 6

`endif

/* File: core/ids_sync.v */
`timescale 1ns/100ps
module ids_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] stage1_q;

    always @(posedge clk) begin
        if (!rst_n) begin
            stage1_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            stage1_q <= din;
            dout <= stage1_q;
        end
    end
endmodule

/* File: core/ids_flash_code.v */
`timescale 1ns/100ps
`include "ids_defs.vh"
module ids_flash_code (
    input wire clk,
    input wire rst_n,
    input wire tick,
    input wire [2:0] code,
    output reg redOn
);
    localparam S_ON = 3'b001;
    localparam S_OFF = 3'b010;
    localparam S_PAUSE = 3'b100;
    localparam [10:0] ON_MS = `IDS_FLASH_ON_MS / `IDS_TICK_MS;
    localparam [10:0] OFF_MS = `IDS_FLASH_OFF_MS / `IDS_TICK_MS;
    localparam [10:0] PAUSE_MS = `IDS_FLASH_PAUSE_MS / `IDS_TICK_MS;

    reg [2:0] state_q;
    reg [10:0] ms_q;
    reg [2:0] pulse_q;

    // A new code opens with its first pulse, so red shows as soon as a fault is seen
    always @(posedge clk) begin
        if (!rst_n) begin
            state_q <= S_ON;
            ms_q <= 11'h000;
            pulse_q <= 3'h0;
            redOn <= 1'b0;
        end else if (code == `IDS_CODE_NONE) begin
            state_q <= S_ON;
            ms_q <= 11'h000;
            pulse_q <= 3'h0;
            redOn <= 1'b0;
        end else if (code == `IDS_CODE_STEADY) begin
            redOn <= 1'b1;
        end else begin
            redOn <= (state_q == S_ON);
            if (tick) begin
                ms_q <= ms_q + 11'h001;
                case (state_q)
                    S_ON: begin
                        if (ms_q >= ON_MS - 11'h001) begin
                            state_q <= S_OFF;
                            ms_q <= 11'h000;
                            pulse_q <= pulse_q + 3'h1;
                        end
                    end
                    S_OFF: begin
                        if (ms_q >= OFF_MS - 11'h001) begin
                            ms_q <= 11'h000;
                            state_q <= (pulse_q >= code) ? S_PAUSE : S_ON;
                        end
                    end
                    S_PAUSE: begin
                        if (ms_q >= PAUSE_MS - 11'h001) begin
                            ms_q <= 11'h000;
                            pulse_q <= 3'h0;
                            state_q <= S_ON;
                        end
                    end
                    default: begin
                        state_q <= S_PAUSE;
                        ms_q <= 11'h000;
                    end
                endcase
            end
        end
    end
endmodule

/* File: core/ids_interlock_diag.v */
// What this block does
// - One to four red pulses for output, cross-wire, temperature warnings; delayed switch-off.
// - Five pulses actuator fault, six handle fault, steady internal; immediate switch-off.
// - Green lit when ready; red lit on any error or failure outside the re-teach release block, and on a warning while the guard is closed.
// - Internal failure keeps both safety outputs off while it persists.
// - Conventional variant clears failure after cause gone and guard reopened then closed.
// - Warning keeps outputs on, disables them after 30 min, clears if cause goes.
// - Closed unlocked: yellow flashes, diagnostic high, safety outputs per monitoring variant.
// - Closed, locking impossible: yellow flashes, diagnostic low, outputs per variant.
// - Closed and locked: yellow steady, safety and diagnostic outputs high.
// - Warning: red flashes, yellow off, diagnostic low; error: all outputs low.
// - Coded variants in teach-in: green off, red on, yellow flashes, outputs low.
// - Re-teach release block: green flashes, red and yellow off, outputs low.
// - Serial variant replaces diagnostic output with chained serial in and out.
// - Chain of up to 31 devices, one request and one response byte each.
// - Response byte carries enable, actuator, locked, inputs, coding, warning, error bits.
// - Bit value one means the condition is present.
// - On gateway communication loss the switching state is held unchanged.
// - Serial failure clears after cause gone and request bit 7 falls or guard opens.
// - Failures at safety outputs clear only at the next release.
// - Detail bytes: output, cross-wire, temperature, actuator, internal, comm, handle bits.
`timescale 1ns/100ps
`include "ids_defs.vh"
module ids_interlock_diag #(
    parameter TICK_CYC = `IDS_TICK_CYC,
    parameter WARN_TICKS = `IDS_WARN_TICKS
) (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire guardClosed,
    input wire lockEngaged,
    input wire magnetIn,
    input wire first_safety_input,
    input wire second_safety_input,
    input wire codingOk,
    input wire faultOut1,
    input wire faultOut2,
    input wire faultCross,
    input wire faultTemp,
    input wire faultActuator,
    input wire faultHandle,
    input wire faultInternal,
    input wire teachActive,
    input wire teachBlock,
    input wire serIn,
    input wire serShift,
    input wire serLatch,
    output reg serOut,
    output reg first_safety_output,
    output reg second_safety_output,
    output reg diagOut,
    output reg magnetOn,
    output reg ledGreen,
    output reg ledRed,
    output reg ledYellow
);
    localparam [14:0] TICK_LAST = TICK_CYC[14:0] - 15'h0001;
    localparam [20:0] WARN_LAST = WARN_TICKS[20:0] - 21'h000001;
    localparam [8:0] BLINK_LAST = `IDS_BLINK_MS / `IDS_TICK_MS - 1;
    localparam [6:0] COMM_LAST = `IDS_COMM_TIMEOUT_MS / `IDS_TICK_MS - 1;

    // Pins from outside pass two flops first
    wire [17:0] pinsRaw = {serLatch, serShift, serIn, teachBlock, teachActive,
        faultInternal, faultHandle, faultActuator, faultTemp, faultCross,
        faultOut2, faultOut1, codingOk, second_safety_input,
        first_safety_input, magnetIn, lockEngaged, guardClosed};
    wire [17:0] pins;

    ids_sync #(
        .W(18)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(pinsRaw),
        .dout(pins)
    );

    wire closed = pins[0];
    wire locked = pins[1];
    wire magPin = pins[2];
    wire inputsOn = pins[3] & pins[4];
    wire codeOk = pins[5];
    wire [3:0] warnSrc = pins[9:6];
    wire actFault = pins[10];
    wire handleFault = pins[11];
    wire intFault = pins[12];
    wire teachA = pins[13];
    wire teachB = pins[14];
    wire sIn = pins[15];
    wire sShift = pins[16];
    wire sLatch = pins[17];

    reg [4:0] ctrl_q;
    reg [7:0] req_q;
    reg [7:0] shReg_q;
    reg [7:0] fail_q;
    reg [20:0] warnCnt_q;
    reg [14:0] tickCnt_q;
    reg [8:0] blinkCnt_q;
    reg blink_q;
    reg [6:0] commCnt_q;
    reg commErr_q;
    reg shiftPrev_q;
    reg latchPrev_q;
    reg closedPrev_q;
    reg openSeen_q;

    wire lockMon = ctrl_q[`IDS_CTRL_LOCKMON];
    wire [1:0] coding = ctrl_q[`IDS_CTRL_CODING_HI:`IDS_CTRL_CODING_LO];
    wire serialMode = ctrl_q[`IDS_CTRL_SERIAL];
    wire p2unlock = ctrl_q[`IDS_CTRL_P2UNLOCK];

    // Free-running millisecond time base
    wire tick = (tickCnt_q == TICK_LAST);

    always @(posedge clk) begin
        if (!rst_n) begin
            tickCnt_q <= 15'h0000;
            blinkCnt_q <= 9'h000;
            blink_q <= 1'b0;
        end else begin
            tickCnt_q <= tick ? 15'h0000 : tickCnt_q + 15'h0001;
            if (tick) begin
                if (blinkCnt_q == BLINK_LAST) begin
                    blinkCnt_q <= 9'h000;
                    blink_q <= ~blink_q;
                end else begin
                    blinkCnt_q <= blinkCnt_q + 9'h001;
                end
            end
        end
    end

    // Serial chain: shift passes bits on downstream, latch swaps in request and response
    wire shiftEdge = sShift & ~shiftPrev_q;
    wire latchEdge = sLatch & ~latchPrev_q;
    wire failAny = |fail_q;
    wire warnAny = |warnSrc;
    wire warnShown = warnAny & ~failAny;
    wire [7:0] respByte = {failAny, warnShown, codeOk, inputsOn, 1'b0,
        closed & locked, closed, first_safety_output};

    always @(posedge clk) begin
        if (!rst_n) begin
            shReg_q <= 8'h00;
            req_q <= 8'h00;
            serOut <= 1'b0;
            shiftPrev_q <= 1'b0;
            latchPrev_q <= 1'b0;
            commCnt_q <= 7'h00;
            commErr_q <= 1'b0;
        end else begin
            shiftPrev_q <= sShift;
            latchPrev_q <= sLatch;
            serOut <= serialMode & shReg_q[7];
            if (serialMode && latchEdge) begin
                req_q <= shReg_q;
                shReg_q <= respByte;
            end else if (serialMode && shiftEdge) begin
                shReg_q <= {shReg_q[6:0], sIn};
            end
            // Lost gateway keeps the last request, so lock and outputs stay put
            if (!serialMode || latchEdge) begin
                commCnt_q <= 7'h00;
                commErr_q <= 1'b0;
            end else if (tick) begin
                if (commCnt_q == COMM_LAST) begin
                    commErr_q <= 1'b1;
                end else begin
                    commCnt_q <= commCnt_q + 7'h01;
                end
            end
        end
    end

    // Magnet command; bit 0 means magnet on for either lock principle
    wire magCmd = serialMode ? req_q[`IDS_REQ_MAGNET] : magPin;
    wire lockReq = magCmd ^ p2unlock;

    // Warning delay restarts from zero only once all warnings have gone or a failure is set
    wire warnExpire = warnAny & (warnCnt_q == WARN_LAST);

    always @(posedge clk) begin
        if (!rst_n) begin
            warnCnt_q <= 21'h000000;
        end else if (!warnAny || failAny) begin
            warnCnt_q <= 21'h000000;
        end else if (tick && warnCnt_q != WARN_LAST) begin
            warnCnt_q <= warnCnt_q + 21'h000001;
        end
    end

    // Failure reset events differ by variant
    wire guardOpened = closedPrev_q & ~closed;
    wire reqResetFell = latchEdge & ~shReg_q[`IDS_REQ_RESET] & req_q[`IDS_REQ_RESET];
    wire convClear = ~serialMode & openSeen_q & closed;
    wire serClear = serialMode & (reqResetFell | guardOpened);
    wire clrEvent = convClear | serClear;
    // Output faults cannot be seen while outputs are off, so the event alone clears them
    wire [7:0] causeNow = {handleFault, 1'b0, intFault, actFault, 4'h0};
    wire [7:0] failSet = {handleFault, 1'b0, intFault, actFault,
        warnExpire ? warnSrc : 4'h0};
    wire [7:0] failClr = {8{clrEvent}} & ~causeNow;

    always @(posedge clk) begin
        if (!rst_n) begin
            fail_q <= 8'h00;
            closedPrev_q <= 1'b0;
            openSeen_q <= 1'b0;
        end else begin
            closedPrev_q <= closed;
            fail_q <= (fail_q & ~failClr) | failSet;
            if (!failAny || convClear) begin
                openSeen_q <= 1'b0;
            end else if (!closed) begin
                openSeen_q <= 1'b1;
            end
        end
    end

    // Red flash code, highest severity first
    reg [2:0] code;
    always @* begin
        code = `IDS_CODE_NONE;
        if (fail_q[5] || intFault) begin
            code = `IDS_CODE_STEADY;
        end else if (fail_q[7]) begin
            code = `IDS_CODE_HANDLE;
        end else if (fail_q[4]) begin
            code = `IDS_CODE_ACT;
        end else if (fail_q[3] || warnSrc[3]) begin
            code = `IDS_CODE_TEMP;
        end else if (fail_q[2] || warnSrc[2] || (warnSrc[1] && warnSrc[0])) begin
            code = `IDS_CODE_CROSS;
        end else if (fail_q[1] || warnSrc[1]) begin
            code = `IDS_CODE_OUT2;
        end else if (fail_q[0] || warnSrc[0]) begin
            code = `IDS_CODE_OUT1;
        end
    end

    wire flashRed;
    ids_flash_code u_flash (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .code(code),
        .redOn(flashRed)
    );

    // Indicator and output decode
    wire teachOn = teachA & (coding != `IDS_CODING_STD);
    wire blockOn = teachB & (coding == `IDS_CODING_RETEACH);
    reg safeD;
    reg diagD;
    reg greenD;
    reg redD;
    reg yellowD;

    always @* begin
        safeD = 1'b0;
        diagD = 1'b0;
        greenD = 1'b1;
        redD = 1'b0;
        yellowD = 1'b0;
        if (teachOn) begin
            greenD = 1'b0;
            redD = 1'b1;
            yellowD = blink_q;
        end else if (blockOn) begin
            greenD = blink_q;
        end else if (failAny || intFault) begin
            redD = flashRed;
        end else if (closed) begin
            safeD = locked | ~lockMon;
            if (warnAny) begin
                redD = flashRed;
            end else if (locked) begin
                yellowD = 1'b1;
                diagD = 1'b1;
            end else begin
                yellowD = blink_q;
                diagD = ~lockReq;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            first_safety_output <= 1'b0;
            second_safety_output <= 1'b0;
            diagOut <= 1'b0;
            magnetOn <= 1'b0;
            ledGreen <= 1'b0;
            ledRed <= 1'b0;
            ledYellow <= 1'b0;
        end else begin
            first_safety_output <= safeD;
            second_safety_output <= safeD;
            diagOut <= diagD & ~serialMode;
            magnetOn <= magCmd;
            ledGreen <= greenD;
            ledRed <= redD;
            ledYellow <= yellowD;
        end
    end

    // Detail bytes for software
    wire [7:0] warnByte = {handleFault, commErr_q, intFault, 1'b0, warnSrc};
    wire [7:0] failByte = {fail_q[7], 1'b0, fail_q[5:0]};
    wire [7:0] indByte = {2'h0, diagOut, first_safety_output, ledYellow,
        ledRed, ledGreen, commErr_q};

    // APB slave, zero wait states; read data sampled in the setup cycle
    wire setup = psel & ~penable;
    wire access = psel & penable;
    reg [31:0] rdD;
    reg errD;

    always @* begin
        rdD = 32'h00000000;
        errD = 1'b0;
        case (paddr)
            `IDS_REG_CTRL: rdD = {27'h0000000, ctrl_q};
            `IDS_REG_REQ: rdD = {24'h000000, req_q};
            `IDS_REG_RESP: rdD = {24'h000000, respByte};
            `IDS_REG_WARN: rdD = {24'h000000, warnByte};
            `IDS_REG_FAIL: rdD = {24'h000000, failByte};
            `IDS_REG_IND: rdD = {24'h000000, indByte};
            default: errD = 1'b1;
        endcase
    end

    assign pready = 1'b1;

    always @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            ctrl_q <= `IDS_CTRL_RESET;
        end else begin
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rdD;
                pslverr <= errD | (pwrite & (paddr != `IDS_REG_CTRL) & ~errD);
            end
            if (access && pwrite && paddr == `IDS_REG_CTRL) begin
                ctrl_q <= pwdata[4:0];
            end
        end
    end
endmodule

/* File: bench/ids_assertions.sv */
`timescale 1ns/100ps
module ids_assertions #(
    parameter TICK_CYC = 20000,
    parameter WARN_TICKS = 1800000
) (
    input wire clk,
    input wire rst_n,
    input wire guardClosed,
    input wire faultTemp,
    input wire faultActuator,
    input wire faultInternal,
    input wire teachActive,
    input wire teachBlock,
    input wire first_safety_output,
    input wire second_safety_output,
    input wire diagOut,
    input wire ledGreen,
    input wire ledRed,
    input wire ledYellow
);
    // Raw pin is ahead of the synchronisers, so this limit already includes their delay
    localparam longint LIM = (WARN_TICKS + 1) * TICK_CYC + 8;
    longint cnt_q;
    longint cnt_d;
    always @* cnt_d = faultTemp ? cnt_q + 1 : 0;
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_hold;
        first_safety_output [*8];
    endsequence
    property p_pair;
        first_safety_output == second_safety_output;
    endproperty
    a_pair: assert property (p_pair) else $error("outputs differ");
    property p_int_off;
        faultInternal [*5] |-> !first_safety_output && !second_safety_output;
    endproperty
    a_int_off: assert property (p_int_off) else $error("internal on");
    property p_act_off;
        faultActuator [*5] |-> !first_safety_output && !diagOut;
    endproperty
    a_act_off: assert property (p_act_off) else $error("actuator on");
    property p_int_red;
        (faultInternal && !teachBlock) [*5] |-> ledRed;
    endproperty
    a_int_red: assert property (p_int_red) else $error("red off");
    property p_warn_diag;
        faultTemp [*5] |-> !diagOut && !ledYellow;
    endproperty
    a_warn_diag: assert property (p_warn_diag) else $error("warn diag");
    property p_teach;
        (teachActive && !teachBlock) [*5] |-> !ledGreen && ledRed && !first_safety_output && !diagOut;
    endproperty
    a_teach: assert property (p_teach) else $error("teach leds");
    property p_open;
        !guardClosed [*5] |-> !first_safety_output && !diagOut;
    endproperty
    a_open: assert property (p_open) else $error("open guard");
    property p_green;
        (!teachActive && !teachBlock) [*4] |-> ledGreen;
    endproperty
    a_green: assert property (p_green) else $error("green off");
    property p_warn_hold;
        first_safety_output && guardClosed && $rose(faultTemp) |-> ##1 s_hold;
    endproperty
    a_warn_hold: assert property (p_warn_hold) else $error("warn drop");
    property p_expire;
        cnt_q == LIM |-> !first_safety_output && !second_safety_output;
    endproperty
    a_expire: assert property (p_expire) else $error("no expiry");
endmodule

bind ids_interlock_diag ids_assertions #(
    .TICK_CYC(TICK_CYC),
    .WARN_TICKS(WARN_TICKS)
) i_ids_assertions (
    .clk(clk),
    .rst_n(rst_n),
    .guardClosed(guardClosed),
    .faultTemp(faultTemp),
    .faultActuator(faultActuator),
    .faultInternal(faultInternal),
    .teachActive(teachActive),
    .teachBlock(teachBlock),
    .first_safety_output(first_safety_output),
    .second_safety_output(second_safety_output),
    .diagOut(diagOut),
    .ledGreen(ledGreen),
    .ledRed(ledRed),
    .ledYellow(ledYellow)
);

/* File: bench/ids_gateway_model.sv */
`timescale 1ns/100ps
module ids_gateway_model (
    input wire clk,
    input wire serOut,
    output reg serIn,
    output reg serShift,
    output reg serLatch
);
    initial begin
        serIn = 1'h0;
        serShift = 1'h0;
        serLatch = 1'h0;
    end
    // Strobes stand five clocks each way: the device synchronises them
    task xfer(input [7:0] req, output [7:0] resp);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                serIn <= req[i];
                repeat (5) @(posedge clk);
                resp[i] = serOut;
                serShift <= 1'h1;
                repeat (5) @(posedge clk);
                serShift <= 1'h0;
            end
            repeat (5) @(posedge clk);
            serLatch <= 1'h1;
            repeat (5) @(posedge clk);
            serLatch <= 1'h0;
            serIn <= ~serIn;
            repeat (5) @(posedge clk);
        end
    endtask
endmodule

/* File: bench/interlock_diagnostic_status_logic_test.sv */
`timescale 1ns/100ps
`include "ids_defs.vh"
module interlock_diagnostic_status_logic_test;
    reg clk;
    reg rst_n;
    reg psel;
    reg penable;
    reg pwrite;
    reg [11:0] paddr;
    reg [31:0] pwdata;
    reg guardClosed;
    reg lockEngaged;
    reg magnetIn;
    reg inOk;
    reg [6:0] flt;
    reg teachActive;
    reg teachBlock;
    wire pready;
    wire [31:0] prdata;
    wire pslverr;
    wire serIn, serShift, serLatch, serOut, safeA, diagOut, magnetOn;
    wire ledGreen, ledRed, ledYellow;
    integer fails;
    integer numChecks;
    integer n;
    integer k;
    reg [31:0] rd;
    reg rerr;
    reg [7:0] resp;
    ids_interlock_diag #(.TICK_CYC(10), .WARN_TICKS(50)) i_dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .guardClosed(guardClosed), .lockEngaged(lockEngaged), .magnetIn(magnetIn),
        .first_safety_input(inOk), .second_safety_input(inOk), .codingOk(inOk),
        .faultOut1(flt[0]), .faultOut2(flt[1]), .faultCross(flt[2]), .faultTemp(flt[3]),
        .faultActuator(flt[4]), .faultHandle(flt[5]), .faultInternal(flt[6]),
        .teachActive(teachActive), .teachBlock(teachBlock), .serIn(serIn),
        .serShift(serShift), .serLatch(serLatch), .serOut(serOut),
        .first_safety_output(safeA), .second_safety_output(), .diagOut(diagOut),
        .magnetOn(magnetOn), .ledGreen(ledGreen), .ledRed(ledRed), .ledYellow(ledYellow));
    ids_gateway_model i_gw (.clk(clk), .serOut(serOut), .serIn(serIn), .serShift(serShift),
        .serLatch(serLatch));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task end_sim;
        begin
            if (fails == 0 && numChecks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [8*6:1] nm, input [31:0] seen, input [31:0] exp);
        begin
            numChecks = numChecks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge clk);
    endtask
    // Idle clock after release so back-to-back calls never assign psel twice at one edge
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'h1;
            penable <= 1'h0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'h1;
            @(posedge clk);
            while (pready !== 1'h1) @(posedge clk);
            rd = prdata;
            rerr = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge clk);
        end
    endtask
    task rg(input [8*6:1] nm, input [11:0] a, input [31:0] exp);
        begin
            apb(1'h0, a, 32'h0);
            chk(nm, rd, exp);
        end
    endtask
    task door(input g, input l, input m);
        begin
            guardClosed <= g;
            lockEngaged <= l;
            magnetIn <= m;
            cyc(8);
        end
    endtask
    task t_regs;
        begin
            rg("ctrl", `IDS_REG_CTRL, 32'h1);
            apb(1'h0, 12'hffc, 32'h0);
            chk("unmap", rerr, 32'h1);
            apb(1'h1, `IDS_REG_RESP, 32'hff);
            chk("roerr", rerr, 32'h1);
        end
    endtask
    task t_lock;
        begin
            door(1'h1, 1'h1, 1'h1);
            chk("safe", safeA, 1'h1);
            chk("diag", diagOut, 1'h1);
            chk("yel", ledYellow, 1'h1);
            chk("red", ledRed, 1'h0);
            rg("resp", `IDS_REG_RESP, 32'h37);
            door(1'h1, 1'h0, 1'h0);
            chk("safe", safeA, 1'h0);
            chk("diag", diagOut, 1'h1);
            door(1'h1, 1'h0, 1'h1);
            chk("diag", diagOut, 1'h0);
            apb(1'h1, `IDS_REG_CTRL, 32'h10);
            cyc(4);
            chk("safe", safeA, 1'h1);
            chk("diag", diagOut, 1'h1);
            apb(1'h1, `IDS_REG_CTRL, 32'h1);
            door(1'h1, 1'h1, 1'h1);
        end
    endtask
    task t_codes;
        for (k = 0; k < 7; k = k + 1) begin
            flt <= 7'h1 << k;
            cyc(8);
            chk("safe", safeA, k < 4);
            chk("red", ledRed, 1'h1);
            rg("det", k < 4 ? `IDS_REG_WARN : `IDS_REG_FAIL,
                k == 5 ? 32'h80 : k == 6 ? 32'h20 : 32'h1 << k);
            flt <= 7'h0;
            cyc(4);
            if (k > 3) chk("held", safeA, 1'h0);
            door(1'h0, 1'h0, 1'h0);
            door(1'h1, 1'h1, 1'h1);
            chk("safe", safeA, 1'h1);
        end
    endtask
    task t_warn;
        begin
            flt <= 7'h8;
            cyc(300);
            flt <= 7'h0;
            cyc(10);
            rg("warn", `IDS_REG_WARN, 32'h0);
            flt <= 7'h8;
            cyc(300);
            chk("safe", safeA, 1'h1);
            chk("diag", diagOut, 1'h0);
            rg("resp", `IDS_REG_RESP, 32'h77);
            cyc(300);
            chk("safe", safeA, 1'h0);
            rg("fail", `IDS_REG_FAIL, 32'h8);
            flt <= 7'h0;
            door(1'h0, 1'h0, 1'h0);
            door(1'h1, 1'h1, 1'h1);
            chk("safe", safeA, 1'h1);
        end
    endtask
    // A gap longer than any inter-pulse gap marks the pause before a group
    task t_flash;
        begin
            flt <= 7'h2;
            n = 0;
            while (n < 5100) begin
                @(posedge clk);
                n = ledRed ? 0 : n + 1;
            end
            n = 0;
            rerr = 1'h0;
            repeat (15000) begin
                @(posedge clk);
                if (ledRed && !rerr) n = n + 1;
                rerr = ledRed;
            end
            chk("pulse", n, 32'h2);
            flt <= 7'h0;
            door(1'h0, 1'h0, 1'h0);
            door(1'h1, 1'h1, 1'h1);
        end
    endtask
    task t_teach;
        begin
            apb(1'h1, `IDS_REG_CTRL, 32'h3);
            teachActive <= 1'h1;
            cyc(8);
            chk("grn", ledGreen, 1'h0);
            chk("safe", safeA, 1'h0);
            teachActive <= 1'h0;
            apb(1'h1, `IDS_REG_CTRL, 32'h5);
            teachBlock <= 1'h1;
            cyc(8);
            chk("red", ledRed, 1'h0);
            chk("yel", ledYellow, 1'h0);
            chk("diag", diagOut, 1'h0);
            teachBlock <= 1'h0;
            apb(1'h1, `IDS_REG_CTRL, 32'h9);
            cyc(8);
        end
    endtask
    task t_serial;
        begin
            i_gw.xfer(8'h01, resp);
            i_gw.xfer(8'h01, resp);
            chk("mag", magnetOn, 1'h1);
            chk("resp", resp, 32'h37);
            chk("diag", diagOut, 1'h0);
            rg("req", `IDS_REG_REQ, 32'h1);
            flt <= 7'h10;
            cyc(8);
            flt <= 7'h0;
            i_gw.xfer(8'h81, resp);
            rg("fail", `IDS_REG_FAIL, 32'h10);
            i_gw.xfer(8'h01, resp);
            rg("fail", `IDS_REG_FAIL, 32'h0);
            cyc(1200);
            rg("warn", `IDS_REG_WARN, 32'h40);
            chk("mag", magnetOn, 1'h1);
            chk("safe", safeA, 1'h1);
        end
    endtask
    initial begin
        fails = 0;
        numChecks = 0;
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        guardClosed = 1'h0;
        lockEngaged = 1'h0;
        magnetIn = 1'h0;
        inOk = 1'h1;
        flt = 7'h0;
        teachActive = 1'h0;
        teachBlock = 1'h0;
        cyc(20);
        rst_n <= 1'h1;
        cyc(3);
        t_regs;
        t_lock;
        t_codes;
        t_warn;
        t_flash;
        t_teach;
        t_serial;
        end_sim;
    end
    initial begin
        repeat (80000) @(posedge clk);
        fails = fails + 1;
        end_sim;
    end
endmodule
